//--- shared/rms_regs.svh
// Register offsets, field positions, reset values and timing counts
// Assumes a 25 MHz system clock and a 32-bit Avalon-MM register bus
//
// Functional notes
// - Clock output tap toggles once the device is ready after reset.
// - In listen mode an event is raised when a packet is received.
// - Preamble listen: wake every T1+T2, receive for T2, else back to sleep.
// - Preamble listen: on preamble found, sequencer stops, receive stays on.
// - Preamble found routes to event line 4 with map 11 and select bit set.
// - Preamble config: sleep idle, start 00, lowpower 1, idle 1, rx 110.
// - Sync listen: receive only for preamble window, low power otherwise.
// - Preamble in window: stay receiving; no sync by T2 end resumes polling.
// - Sync match: raise sync event, stop sequencer, stay in receive.
// - Sync config: rx 101 stops on sync, expiry 10 to lowpower selection.
// - Beacon repeats only with repeat bit set and sequencer running.
// - Beacon: transmit every T1+T2, return to idle after packet sent.
// - Beacon loops forever until the halt bit is set.
// - Beacon config: idle 0 to transmit on T1, tx 0 to lowpower selection.
`ifndef RMS_REGS_SVH
`define RMS_REGS_SVH

// ============================================================
// Register offsets (word addresses)
`define RMS_OFS_CTRL      4'h0
`define RMS_OFS_SEQCFG    4'h1
`define RMS_OFS_FIRST_SLEEP_TIMER    4'h2
`define RMS_OFS_SECOND_WINDOW_TIMER    4'h3
`define RMS_OFS_WINDOW    4'h4
`define RMS_OFS_DIOMAP    4'h5
`define RMS_OFS_STATUS    4'h6

// ============================================================
// Control fields
`define RMS_CTRL_START    0
`define RMS_CTRL_HALT     1
`define RMS_CTRL_BEACON   2

// Sequencer configuration fields
`define RMS_CFG_IDLE      0
`define RMS_CFG_START_LO  1
`define RMS_CFG_LOWPWR    3
`define RMS_CFG_IDLE_NEXT 4
`define RMS_CFG_RX_LO     5
`define RMS_CFG_EXP_LO    8
`define RMS_CFG_TX_NEXT   10

// Event mapping fields
`define RMS_MAP_EVENT_LINE_4_LO   0
`define RMS_MAP_PRE_SEL   2

// ============================================================
// Reset values
`define RMS_SEQCFG_RST    11'h000
`define RMS_TIMER_RST     16'h0001
`define RMS_WINDOW_RST    16'h0001

// ============================================================
// Timing
`define RMS_CLK_MHZ       25
`define RMS_READY_US      5000
`define RMS_READY_CYC     (`RMS_READY_US * `RMS_CLK_MHZ)
`define RMS_TICK_NS       64000
`define RMS_TICK_CYC      ((`RMS_TICK_NS) / 40)

`endif

//--- shared/rms_pkg.sv
// Types shared by the radio mode sequencer
// Assumes the constants header is included alongside
package rms_pkg;

  // ============================================================
  // Sequencer states
  typedef enum logic [5:0] {
    RMS_OFF    = 6'h01,
    RMS_LOWSEL = 6'h02,
    RMS_IDLE   = 6'h04,
    RMS_RX     = 6'h08,
    RMS_TX     = 6'h10,
    RMS_STBY   = 6'h20
  } rms_state_t;

  // Radio events from the modem
  typedef struct packed {
    logic preamble_found;
    logic sync_match;
    logic frame_ready_event;
    logic tx_done_event;
  } rms_events_t;

  // Radio operating mode requested of the modem
  typedef struct packed {
    logic rx_on;
    logic tx_on;
    logic sleep_on;
    logic stby_on;
  } rms_radio_t;

endpackage

//--- rtl/rms_sequencer.sv
// Top-level mode sequencer with Avalon-MM register slave
// Assumes modem events are one-cycle pulses synchronous to sys_clk
//
// Added by the designer: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "rms_regs.svh"

module rms_sequencer
  import rms_pkg::*;
#(
  parameter int READY_CYC = `RMS_READY_CYC,
  parameter int TICK_CYC  = `RMS_TICK_CYC
)
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  rms_events_t      events,
  output rms_radio_t       radio,
  output logic             clock_output_tap,
  output logic             event_line_4,
  output logic             irq_frame
);

  // Refuse counts that the counters cannot hold
  if (READY_CYC < 1 || TICK_CYC < 1 || TICK_CYC > 65536)
  begin : g_bad_counts
    $error("rms_sequencer: counts out of range");
  end

  // ============================================================
  // State
  typedef struct packed {
    rms_state_t  st;
    logic        running;
    logic        in_window;
    logic        pre_seen;
    logic        phase2;
    logic [31:0] ready_cnt;
    logic        ready;
    logic [15:0] tick_cnt;
    logic [15:0] tmr;
    logic [15:0] win;
    logic        beacon_repeat_en;
    logic [10:0] seqcfg;
    logic [15:0] t1;
    logic [15:0] t2;
    logic [15:0] rx_preamble_window;
    logic [2:0]  dio;
    logic        ack;
    logic [31:0] rdata;
    logic        tap;
    logic        ev4;
    logic        irq;
  } rms_s_t;

  rms_s_t r;
  rms_s_t next_r;

  logic       idle_kind_sel;
  logic [1:0] start_next_sel;
  logic       lowpwr_next_sel;
  logic       idle_next_sel;
  logic [2:0] rx_next_sel;
  logic [1:0] rx_expiry_next_sel;
  logic       tx_next_sel;
  logic       wr;
  logic       rd;
  logic       tick;

  assign idle_kind_sel      = r.seqcfg[`RMS_CFG_IDLE];
  assign start_next_sel     = r.seqcfg[`RMS_CFG_START_LO +: 2];
  assign lowpwr_next_sel    = r.seqcfg[`RMS_CFG_LOWPWR];
  assign idle_next_sel      = r.seqcfg[`RMS_CFG_IDLE_NEXT];
  assign rx_next_sel        = r.seqcfg[`RMS_CFG_RX_LO +: 3];
  assign rx_expiry_next_sel = r.seqcfg[`RMS_CFG_EXP_LO +: 2];
  assign tx_next_sel        = r.seqcfg[`RMS_CFG_TX_NEXT];

  // Reads load data in the first cycle; writes land when waitrequest is low
  assign wr              = avs_write && r.ack;
  assign rd              = avs_read && !r.ack;
  assign avs_waitrequest = (avs_read || avs_write) && !r.ack;
  assign avs_readdata    = r.rdata;
  assign clock_output_tap = r.tap;
  assign event_line_4    = r.ev4;
  assign irq_frame       = r.irq;
  assign tick            = (r.tick_cnt == 16'(TICK_CYC - 1));

  function automatic logic [15:0] rms_merge(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  be);
    logic [15:0] v;
    v = old;
    if (be[0])
      v[7:0] = d[7:0];
    if (be[1])
      v[15:8] = d[15:8];
    return v;
  endfunction

  function automatic logic [15:0] rms_load(input logic [15:0] v);
    return (v == 16'h0000) ? 16'h0001 : v;
  endfunction

  always_comb
  begin
    next_r     = r;
    next_r.ack = (avs_read || avs_write) && !r.ack;

    // ============================================================
    // Readiness and clock tap
    if (!r.ready)
    begin
      next_r.ready_cnt = r.ready_cnt + 32'h0000_0001;
      if (r.ready_cnt == 32'(READY_CYC - 1))
        next_r.ready = 1'b1;
    end
    next_r.tap = r.ready ? ~r.tap : 1'b0;

    // timers tick on RC time base
    next_r.tick_cnt = tick ? 16'h0000 : r.tick_cnt + 16'h0001;

    // ============================================================
    // Register writes
    if (wr)
    begin
      case (avs_address)
        `RMS_OFS_CTRL:
        begin
          if (avs_byteenable[0])
          begin
            next_r.beacon_repeat_en = avs_writedata[`RMS_CTRL_BEACON];
            if (avs_writedata[`RMS_CTRL_START] && !r.running)
            begin
              next_r.running = 1'b1;
              next_r.phase2  = 1'b0;
              next_r.st      = RMS_LOWSEL;
              if (start_next_sel != 2'b00)
                next_r.st = RMS_STBY;
            end
            if (avs_writedata[`RMS_CTRL_HALT])
            begin
              next_r.running = 1'b0;
              next_r.st      = RMS_OFF;
            end
          end
        end
        `RMS_OFS_SEQCFG: next_r.seqcfg = 11'(rms_merge(16'(r.seqcfg), avs_writedata,
                                                       avs_byteenable));
        `RMS_OFS_FIRST_SLEEP_TIMER: next_r.t1 = rms_merge(r.t1, avs_writedata, avs_byteenable);
        `RMS_OFS_SECOND_WINDOW_TIMER: next_r.t2 = rms_merge(r.t2, avs_writedata, avs_byteenable);
        `RMS_OFS_WINDOW:
          next_r.rx_preamble_window = rms_merge(r.rx_preamble_window, avs_writedata,
                                                avs_byteenable);
        `RMS_OFS_DIOMAP:
          if (avs_byteenable[0])
            next_r.dio = avs_writedata[2:0];
        default: next_r.dio = r.dio;
      endcase
    end
    if (rd)
    begin
      case (avs_address)
        `RMS_OFS_CTRL:   next_r.rdata = {29'h0, r.beacon_repeat_en, 1'b0, r.running};
        `RMS_OFS_SEQCFG: next_r.rdata = {21'h0, r.seqcfg};
        `RMS_OFS_FIRST_SLEEP_TIMER: next_r.rdata = {16'h0, r.t1};
        `RMS_OFS_SECOND_WINDOW_TIMER: next_r.rdata = {16'h0, r.t2};
        `RMS_OFS_WINDOW: next_r.rdata = {16'h0, r.rx_preamble_window};
        `RMS_OFS_DIOMAP: next_r.rdata = {29'h0, r.dio};
        `RMS_OFS_STATUS: next_r.rdata = {24'h0, r.ready, r.irq, r.st};
        default:         next_r.rdata = 32'h0000_0000;
      endcase
    end

    // ============================================================
    // preamble to event line 4
    next_r.ev4 = events.preamble_found && r.dio[`RMS_MAP_PRE_SEL]
                 && (r.dio[`RMS_MAP_EVENT_LINE_4_LO +: 2] == 2'b11);
    next_r.irq = events.frame_ready_event || events.sync_match;

    // ============================================================
    // Sequencer
    if (r.running && !(wr && avs_address == `RMS_OFS_CTRL))
    begin
      case (r.st)
        RMS_LOWSEL:
        begin
          next_r.st     = lowpwr_next_sel ? RMS_IDLE : RMS_OFF;
          // Finish what is left of the second timer before the first starts
          next_r.phase2 = r.phase2 && (r.tmr != 16'h0000);
          next_r.tmr    = next_r.phase2 ? r.tmr : rms_load(r.t1);
          if (!lowpwr_next_sel)
            next_r.running = 1'b0;
        end
        RMS_IDLE:
        begin
          if (tick)
          begin
            next_r.tmr = r.tmr - 16'h0001;
            if (r.tmr == 16'h0001)
            begin
              if (r.phase2)
              begin
                next_r.phase2 = 1'b0;
                next_r.tmr    = rms_load(r.t1);
              end
              else
              begin
                next_r.st = idle_next_sel ? RMS_RX : RMS_TX;
                if (!idle_next_sel && !r.beacon_repeat_en)
                begin
                  next_r.st      = RMS_OFF;
                  next_r.running = 1'b0;
                end
                next_r.tmr       = rms_load(r.t2);
                next_r.win       = rms_load(r.rx_preamble_window);
                next_r.in_window = 1'b1;
                next_r.pre_seen  = 1'b0;
              end
            end
          end
        end
        RMS_RX:
        begin
          if (tick)
          begin
            next_r.tmr = (r.tmr == 16'h0000) ? 16'h0000 : r.tmr - 16'h0001;
            next_r.win = (r.win == 16'h0000) ? 16'h0000 : r.win - 16'h0001;
          end
          if (events.preamble_found)
            next_r.pre_seen = 1'b1;
          if (rx_next_sel == 3'b110 && events.preamble_found)
          begin
            next_r.running = 1'b0;
            next_r.st      = RMS_OFF;
          end
          else if (rx_next_sel == 3'b101 && events.sync_match)
          begin
            next_r.running  = 1'b0;
            next_r.st       = RMS_OFF;
            next_r.pre_seen = 1'b1;
          end
          else if (rx_next_sel == 3'b101 && tick && r.win == 16'h0001 && !r.pre_seen
                   && !events.preamble_found)
          begin
            next_r.st     = (rx_expiry_next_sel == 2'b10) ? RMS_LOWSEL : RMS_OFF;
            next_r.phase2 = 1'b1;
            if (rx_expiry_next_sel != 2'b10)
              next_r.running = 1'b0;
          end
          else if (tick && r.tmr == 16'h0001)
            next_r.st = RMS_LOWSEL;
        end
        // back to lowpower after packet sent, or off when the tx next bit is set
        RMS_TX:
        begin
          // Second timer keeps running so the period stays first plus second
          if (tick && r.tmr != 16'h0000)
            next_r.tmr = r.tmr - 16'h0001;
          if (events.tx_done_event)
          begin
            next_r.st     = tx_next_sel ? RMS_OFF : RMS_LOWSEL;
            next_r.phase2 = 1'b1;
            if (tx_next_sel)
              next_r.running = 1'b0;
          end
        end
        default: next_r.st = r.st;
      endcase
    end
  end

  // ============================================================
  // Radio mode: receive persists after sequencer stops in receive
  always_comb
  begin
    radio.rx_on    = (r.st == RMS_RX) || (!r.running && r.pre_seen);
    radio.tx_on    = (r.st == RMS_TX);
    radio.sleep_on = (r.st == RMS_IDLE) && idle_kind_sel;
    radio.stby_on  = !radio.rx_on && !radio.tx_on && !radio.sleep_on;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      r        <= '0;
      r.st     <= RMS_OFF;
      r.seqcfg <= `RMS_SEQCFG_RST;
      r.t1     <= `RMS_TIMER_RST;
      r.t2     <= `RMS_TIMER_RST;
      r.rx_preamble_window <= `RMS_WINDOW_RST;
    end
    else
      r <= next_r;
  end

endmodule

//--- testbench/rms_modem_model.sv
// Modem stand-in that answers the sequencer's radio mode with event pulses
// Assumes inject bits pick preamble, sync and frame pulses during receive
`timescale 1ns/1ps
module rms_modem_model
  import rms_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  rms_radio_t      radio,
  input  wire logic [2:0] inject,
  output rms_events_t     events
);
  // ==========
  // Event timing from start of each receive or transmit
  logic [7:0] cnt;
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
    begin
      cnt    <= 8'h00;
      events <= '0;
    end
    else
    begin
      cnt <= (radio.rx_on || radio.tx_on) ? cnt + {7'h00, cnt != 8'hFF} : 8'h00;
      events.preamble_found    <= radio.rx_on && cnt == 8'h02 && inject[0];
      events.sync_match        <= radio.rx_on && cnt == 8'h06 && inject[1];
      events.frame_ready_event <= radio.rx_on && cnt == 8'h0A && inject[2];
      events.tx_done_event     <= radio.tx_on && cnt == 8'h03;
    end
endmodule

//--- testbench/rms_properties.sv
// Concurrent checks on the sequencer ports
// Assumes bind onto rms_sequencer, tracking config through bus writes
`timescale 1ns/1ps
module rms_properties
  import rms_pkg::*;
#(parameter int READY_CYC = 20)
(
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input rms_events_t      events,
  input rms_radio_t       radio,
  input wire logic        clock_output_tap,
  input wire logic        event_line_4,
  input wire logic        irq_frame
);
  // ==========
  // Helper state
  int          cnt;
  logic [2:0]  map_q;
  logic [10:0] cfg_q;
  logic        acc;
  assign acc = avs_write && !avs_waitrequest;
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
    begin
      cnt   <= 0;
      map_q <= 3'h0;
      cfg_q <= 11'h000;
    end
    else
    begin
      cnt   <= (cnt < READY_CYC + 3) ? cnt + 1 : cnt;
      map_q <= (acc && avs_address == 4'h5) ? avs_writedata[2:0] : map_q;
      cfg_q <= (acc && avs_address == 4'h1) ? avs_writedata[10:0] : cfg_q;
    end
  // ==========
  // Properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_tap_quiet;
    cnt < READY_CYC - 1 |-> !clock_output_tap;
  endproperty
  property p_tap_run;
    cnt == READY_CYC + 3 |-> clock_output_tap != $past(clock_output_tap);
  endproperty
  property p_line4;
    1 |=> event_line_4 == $past(events.preamble_found && map_q == 3'h7);
  endproperty
  property p_irq;
    events.frame_ready_event || events.sync_match |=> irq_frame;
  endproperty
  property p_excl;
    !(radio.rx_on && radio.tx_on);
  endproperty
  property p_wait;
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  property p_pre_hold;
    radio.rx_on && events.preamble_found && cfg_q[7:5] == 3'h6 |=> radio.rx_on [*8];
  endproperty
  property p_sync_hold;
    radio.rx_on && events.sync_match && cfg_q[7:5] == 3'h5 |=> radio.rx_on [*8];
  endproperty
  property p_tx_end;
    radio.tx_on && events.tx_done_event && !cfg_q[10] |-> ##[1:3] !radio.tx_on;
  endproperty
  a_tap_quiet: assert property (p_tap_quiet) else $error("tap early");
  a_tap_run: assert property (p_tap_run) else $error("tap idle");
  a_line4: assert property (p_line4) else $error("line4 wrong");
  a_irq: assert property (p_irq) else $error("irq missing");
  a_excl: assert property (p_excl) else $error("rx and tx");
  a_wait: assert property (p_wait) else $error("wait shape");
  a_pre_hold: assert property (p_pre_hold) else $error("rx dropped");
  a_sync_hold: assert property (p_sync_hold) else $error("rx dropped");
  a_tx_end: assert property (p_tx_end) else $error("tx stays");
  c_tx: cover property ($rose(radio.tx_on));
  c_line4: cover property (event_line_4);
  c_irq: cover property (irq_frame);
endmodule

bind rms_sequencer rms_properties #(.READY_CYC(READY_CYC)) u_rms_properties (.*);

//--- testbench/test_rms_sequencer.sv
// Self-checking bench for the radio mode sequencer
// Assumes short READY_CYC and TICK_CYC and a modem stand-in for events
`timescale 1ns/1ps
module test_rms_sequencer
  import rms_pkg::*;
;
  localparam int RC = 20;
  localparam int TK = 4;
  logic        sys_clk = 0;
  logic        nrst = 0;
  logic        avs_read = 0;
  logic        avs_write = 0;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic        avs_waitrequest, tap, line4, irq, l4, ir, s;
  logic [2:0]  inj = 3'h0;
  rms_events_t ev;
  rms_radio_t  radio;
  int          miscompares = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          t0, t1;

  rms_sequencer #(.READY_CYC(RC), .TICK_CYC(TK)) u_rms_sequencer (.sys_clk(sys_clk),
    .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h3), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .events(ev), .radio(radio),
    .clock_output_tap(tap), .event_line_4(line4), .irq_frame(irq));
  rms_modem_model u_rms_modem_model (.sys_clk(sys_clk), .nrst(nrst), .radio(radio),
    .inject(inj), .events(ev));

  // ==========
  // Clock, timeout, event capture
  initial
    forever #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc++;
    l4 <= nrst && (l4 || line4);
    ir <= nrst && (ir || irq);
    if (cyc == 6000)
    begin
      miscompares++;
      results;
    end
  end

  // ==========
  // Shared tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %0t %s: %h vs %h", $time, m, seen, exp);
    end
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    // Hold until waitrequest is sampled low at a rising edge; read data stand there
    do
      @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task wt(input logic k, input logic v, output int t);
    t = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      t++;
    end
    while ((k ? radio.tx_on : radio.rx_on) !== v && t < 400);
    chk(t < 400, 1, "wait");
  endtask
  task rst;
    // reset pin driven low, then released
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (RC + 3) @(posedge sys_clk);
    #1 s = tap;
    @(posedge sys_clk);
    #1 chk(tap, !s, "tap");
  endtask
  task setup(input logic [15:0] a, b, input logic [10:0] c, input logic [31:0] ctl);
    bus(1, 4'h2, a);
    bus(1, 4'h3, b);
    bus(1, 4'h4, 1);
    bus(1, 4'h5, 7);
    bus(1, 4'h1, c);
    bus(1, 4'h0, ctl);
  endtask
  task slept;
    repeat (3) @(posedge sys_clk);
    #1 chk(radio.sleep_on, 1, "sleep");
  endtask

  // ==========
  // Scenarios
  task s_regs;
    chk(radio, 4'h1, "rst radio");
    bus(0, 4'h2, 0);
    chk(q, 32'h1, "first_sleep_timer");
    bus(0, 4'h1, 0);
    chk(q, 0, "seqcfg");
    bus(1, 4'hF, 32'hFFFF);
    bus(0, 4'hF, 0);
    chk(q, 0, "unmapped");
  endtask
  task s_beacon;
    rst;
    setup(2, 3, 11'h009, 32'h5);
    wt(1, 1, t0);
    wt(1, 0, t0);
    chk(t0 <= 8, 1, "tx long");
    slept;
    wt(1, 1, t1);
    chk(t0 + t1 + 3 >= 5 * TK - 4 && t0 + t1 + 3 <= 5 * TK + 4, 1, "period");
    bus(1, 4'h0, 2);
    s = 0;
    repeat (60)
    begin
      @(posedge sys_clk);
      #1 s = s | radio.tx_on;
    end
    chk(s, 0, "halt");
  endtask
  task s_pre;
    rst;
    setup(2, 3, 11'h0D9, 32'h1);
    wt(0, 1, t0);
    wt(0, 0, t0);
    chk(t0 >= 3 * TK - 4 && t0 <= 3 * TK + 4, 1, "rx len");
    slept;
    inj <= 3'h1;
    wt(0, 1, t0);
    repeat (80) @(posedge sys_clk);
    #1 chk(radio.rx_on, 1, "rx held");
    chk(l4, 1, "line4");
    bus(0, 4'h0, 0);
    chk(q[0], 0, "seq off");
  endtask
  task s_sync;
    rst;
    inj <= 3'h0;
    setup(1, 4, 11'h2B9, 32'h1);
    wt(0, 1, t0);
    wt(0, 0, t0);
    chk(t0 <= TK + 3, 1, "window");
    inj <= 3'h1;
    wt(0, 1, t0);
    wt(0, 0, t0);
    chk(t0 > TK + 3 && t0 <= 4 * TK + 4, 1, "t2 end");
    inj <= 3'h7;
    wt(0, 1, t0);
    repeat (80) @(posedge sys_clk);
    #1 chk(radio.rx_on, 1, "rx held");
    chk(ir, 1, "irq");
    bus(0, 4'h0, 0);
    chk(q[0], 0, "seq off");
  endtask
  task results;
    $display("Tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    rst;
    s_regs;
    s_beacon;
    s_pre;
    s_sync;
    results;
  end
endmodule
